//--- ufc_queue_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module ufc_queue_ctrl
	import ufc_pkg::*;
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Receive shift register side
	input wire logic rx_wr,
	input wire logic [7:0] rx_byte,
	input wire ufc_line_err_t rx_err,
	input wire logic char_tick,
	// Transmit shift register side
	input wire logic tx_take,
	output logic tx_avail,
	output logic [7:0] tx_head,
	// Modem status logic
	input wire logic modem_pend,
	// Interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////
	// State
	// Both queues and every register live in this one struct
	typedef struct packed {
		logic [15:0][7:0] rx_mem; // Receive storage
		logic [15:0][7:0] tx_mem; // Send storage
		logic [3:0] rx_rd; // Receive read pointer
		logic [3:0] rx_wrp; // Receive write pointer
		logic [4:0] rx_cnt; // Receive fill
		logic [3:0] tx_rd; // Send read pointer
		logic [3:0] tx_wrp; // Send write pointer
		logic [4:0] tx_cnt; // Send fill
		logic q_en; // queues_enable
		logic [1:0] thr_sel; // rx_threshold_sel
		logic xfer_mode; // Stored, unused
		logic [3:0] ie; // Source enables
		ufc_line_err_t lerr; // Sticky line errors
		logic thre_pend; // Holding empty pending
		logic [2:0] idle_chars; // Character times without activity
		logic [2:0] snap_src; // Source code given by the last read
		logic [UFC_EV_W-1:0] ev_stat; // Sticky events
		logic [UFC_EV_W-1:0] ev_en; // Event enables
		logic [UFC_EV_W-1:0] ev_prev; // Previous source levels
		logic [31:0] prdata; // Read data
		logic pready; // Access phase ready
		logic pslverr; // Unmapped access
		logic [7:0] tx_head; // Byte offered to the shifter
		logic tx_avail; // Send queue not empty
		logic irq; // Interrupt line
	} ufc_state_t;

	// Registered copy, and the copy that the comb process fills
	ufc_state_t s_r; // Registered state
	ufc_state_t s_nxt; // Next state

	// Decode and condition nets, filled by the two comb processes
	// APB phase decode
	logic setup; // APB setup cycle
	logic done; // APB access completes
	logic [9:0] waddr; // Word-aligned address
	logic mapped; // Address decodes
	logic [4:0] cap; // Queue capacity in the current mode
	logic [4:0] trig; // Selected threshold
	logic rxav; // Data available condition
	logic tmo; // Timeout condition
	logic line_pend; // Any line error pending
	logic [2:0] src; // Highest pending source code
	logic pend; // Enabled source pending
	logic [7:0] ident; // pending_interrupt_identity value
	logic [UFC_EV_W-1:0] lvl; // Source levels for events
	logic rx_pop; // Receive byte taken by software
	logic rx_push; // Receive byte stored
	logic tx_pop; // Send byte taken by shifter
	logic tx_push; // Send byte stored by software
	logic qc_wr; // Queue control write
	logic [7:0] wb; // Written byte

	////////////////////////////////////////////////////////////////////
	// Source conditions and identity value
	always_comb begin
		// Capacity: sixteen in queue mode, else one holding byte
		cap = s_r.q_en ? UFC_DEPTH : UFC_HOLD_DEPTH;
		// Threshold byte count from the selected code
		unique case (s_r.thr_sel)
			2'b00: trig = UFC_TRIG_0;
			2'b01: trig = UFC_TRIG_1;
			2'b10: trig = UFC_TRIG_2;
			2'b11: trig = UFC_TRIG_3;
		endcase
		// Threshold in queue mode, one byte otherwise
		rxav = s_r.q_en ? (s_r.rx_cnt >= trig) : (s_r.rx_cnt != 5'h00);
		tmo = s_r.q_en && (s_r.rx_cnt != 5'h00) &&
			(s_r.idle_chars >= UFC_TMO_CHARS);
		// Any sticky line error makes the line source pending
		line_pend = |s_r.lerr;
		// Fixed priority chain, each gated by its enable
		// Assume a source until the last branch finds none
		pend = 1'b1;
		if (s_r.ie[UFC_IE_LINE] && line_pend) begin
			src = UFC_SRC_LINE;
		end else if (s_r.ie[UFC_IE_RXAV] && rxav) begin
			src = UFC_SRC_RXAV;
		end else if (s_r.ie[UFC_IE_RXAV] && tmo) begin
			src = UFC_SRC_TMO;
		end else if (s_r.ie[UFC_IE_THRE] && s_r.thre_pend) begin
			src = UFC_SRC_THRE;
		end else if (s_r.ie[UFC_IE_MODEM] && modem_pend) begin
			src = UFC_SRC_MODEM;
		end else begin
			src = UFC_SRC_NONE;
			pend = 1'b0;
		end
		// Identity: mode bits, reserved zeros, code, none pending
		ident = {s_r.q_en, s_r.q_en, 2'b00, src, ~pend};
		// Levels watched for rising edges by the event logic
		lvl = '0;
		lvl[UFC_EV_LINE] = line_pend;
		lvl[UFC_EV_RXAV] = rxav;
		lvl[UFC_EV_THRE] = s_r.thre_pend;
		lvl[UFC_EV_MODEM] = modem_pend;
		lvl[UFC_EV_TMO] = tmo;
	end

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_nxt = s_r;
		// APB phases and the word address
		setup = psel && !penable;
		done = psel && penable && s_r.pready;
		waddr = paddr[11:2];
		wb = pwdata[7:0];
		// Registers 0 to 6 exist; anything above answers an error
		mapped = (waddr <= 10'(UFC_IDX_EVT_EN));
		// Software strobes: a full or empty queue ignores them
		rx_pop = done && !pwrite && (waddr == 10'(UFC_IDX_DATA)) &&
			(s_r.rx_cnt != 5'h00);
		tx_push = done && pwrite && (waddr == 10'(UFC_IDX_DATA)) &&
			(s_r.tx_cnt < cap);
		qc_wr = done && pwrite && (waddr == 10'(UFC_IDX_QCTL));
		// Shifter strobes: a push needs room, a pop needs a byte
		rx_push = rx_wr && (s_r.rx_cnt < cap);
		tx_pop = tx_take && (s_r.tx_cnt != 5'h00);

		// Setup cycle: answer is latched, so the access sees a frozen value
		// Zero wait states: ready always follows a setup cycle
		s_nxt.pready = setup;
		if (setup) begin
			s_nxt.pslverr = !mapped;
			s_nxt.prdata = 32'h0000_0000;
			if (!pwrite) begin
				unique case (waddr)
					10'(UFC_IDX_DATA): s_nxt.prdata[7:0] = s_r.rx_mem[s_r.rx_rd];
					10'(UFC_IDX_IRQ_EN): s_nxt.prdata[3:0] = s_r.ie;
					// Identity read also records the code it reports
					10'(UFC_IDX_QCTL): begin
						s_nxt.prdata[7:0] = ident;
						s_nxt.snap_src = pend ? src : UFC_SRC_NONE;
					end
					10'(UFC_IDX_LSTAT): s_nxt.prdata[4:0] =
						{s_r.rx_cnt != 5'h00, s_r.lerr};
					10'(UFC_IDX_EVT_STAT): s_nxt.prdata[UFC_EV_W-1:0] = s_r.ev_stat;
					10'(UFC_IDX_EVT_EN): s_nxt.prdata[UFC_EV_W-1:0] = s_r.ev_en;
					default: s_nxt.prdata = 32'h0000_0000;
				endcase
			end
		end

		// Register writes
		// All of them land on the completing edge of the access
		if (done && pwrite && waddr == 10'(UFC_IDX_IRQ_EN)) begin
			s_nxt.ie = pwdata[3:0];
		end
		// Event enables
		if (done && pwrite && waddr == 10'(UFC_IDX_EVT_EN)) begin
			s_nxt.ev_en = pwdata[UFC_EV_W-1:0];
		end
		if (qc_wr && wb[UFC_QC_EN]) begin
			// Other fields only take effect with the enable set
			s_nxt.thr_sel = wb[UFC_QC_THR_LO +: 2];
			s_nxt.xfer_mode = wb[UFC_QC_XFER_MODE];
		end
		// The enable itself is taken from every control write
		if (qc_wr) begin
			s_nxt.q_en = wb[UFC_QC_EN];
		end

		// Receive queue: push from shifter, pop by software
		if (rx_push) begin
			s_nxt.rx_mem[s_r.rx_wrp] = rx_byte;
			s_nxt.rx_wrp = s_r.rx_wrp + 4'h1;
		end
		// A software pop advances the read pointer
		if (rx_pop) begin
			s_nxt.rx_rd = s_r.rx_rd + 4'h1;
		end
		// Count moves by push minus pop; both may fall in one cycle
		s_nxt.rx_cnt = s_r.rx_cnt + 5'(rx_push) - 5'(rx_pop);
		// Hold byte in non-queue mode: keep pointers on slot zero
		if (!s_r.q_en) begin
			s_nxt.rx_wrp = 4'h0;
			s_nxt.rx_rd = 4'h0;
		end

		// Send queue: push by software, pop by shifter
		if (tx_push) begin
			s_nxt.tx_mem[s_r.tx_wrp] = wb;
			s_nxt.tx_wrp = s_r.tx_wrp + 4'h1;
		end
		// A shifter pop advances the read pointer
		if (tx_pop) begin
			s_nxt.tx_rd = s_r.tx_rd + 4'h1;
		end
		// Count moves by push minus pop
		s_nxt.tx_cnt = s_r.tx_cnt + 5'(tx_push) - 5'(tx_pop);
		// Single holding byte in non-queue mode
		if (!s_r.q_en) begin
			s_nxt.tx_wrp = 4'h0;
			s_nxt.tx_rd = 4'h0;
		end

		// Flushes win over same-cycle traffic; shifters are not touched
		// A change of the enable empties both queues as well
		if (qc_wr && ((wb[UFC_QC_EN] && wb[UFC_QC_RX_FLUSH]) ||
			(wb[UFC_QC_EN] != s_r.q_en))) begin
			s_nxt.rx_rd = 4'h0;
			s_nxt.rx_wrp = 4'h0;
			s_nxt.rx_cnt = 5'h00;
		end
		if (qc_wr && ((wb[UFC_QC_EN] && wb[UFC_QC_TX_FLUSH]) ||
			(wb[UFC_QC_EN] != s_r.q_en))) begin
			s_nxt.tx_rd = 4'h0;
			s_nxt.tx_wrp = 4'h0;
			s_nxt.tx_cnt = 5'h00;
		end

		// Idle character count; any receive queue activity restarts it
		// Counting stops at the limit, so the flag stays up
		if (rx_push || rx_pop || s_nxt.rx_cnt == 5'h00) begin
			s_nxt.idle_chars = 3'h0;
		end else if (char_tick && s_r.idle_chars < UFC_TMO_CHARS) begin
			s_nxt.idle_chars = s_r.idle_chars + 3'h1;
		end

		// Line errors: status read clears, new errors win
		if (done && !pwrite && waddr == 10'(UFC_IDX_LSTAT)) begin
			s_nxt.lerr = '0;
		end
		// New errors are ORed in after the clear
		s_nxt.lerr = s_nxt.lerr | rx_err;
		// A byte that meets a full queue is an overrun
		s_nxt.lerr.ovr = s_nxt.lerr.ovr | (rx_wr && !rx_push);

		// Holding empty: cleared by send write or identity read as source
		if (tx_push || (done && !pwrite && waddr == 10'(UFC_IDX_QCTL) &&
			s_r.snap_src == UFC_SRC_THRE)) begin
			s_nxt.thre_pend = 1'b0;
		end
		// Set wins: an emptied queue raises the source again
		if (s_nxt.tx_cnt == 5'h00 && (s_r.tx_cnt != 5'h00 || qc_wr)) begin
			s_nxt.thre_pend = 1'b1;
		end

		// Sticky events on rising source levels; set wins over clear
		// Write-one-to-clear first, then the new rising edges
		if (done && pwrite && waddr == 10'(UFC_IDX_EVT_CLR)) begin
			s_nxt.ev_stat = s_r.ev_stat & ~pwdata[UFC_EV_W-1:0];
		end
		s_nxt.ev_stat = s_nxt.ev_stat | (lvl & ~s_r.ev_prev);
		s_nxt.ev_prev = lvl;
		// Level interrupt from the enabled sticky bits
		s_nxt.irq = |(s_nxt.ev_stat & s_nxt.ev_en);

		// Registered send head
		// Taken from the next state, so the shifter sees no lag
		s_nxt.tx_head = s_nxt.tx_mem[s_nxt.tx_rd];
		s_nxt.tx_avail = (s_nxt.tx_cnt != 5'h00);

		// Clock enable freezes everything
		// Nothing above moves while the enable is low
		if (!pce) begin
			s_nxt = s_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Constants only; identity bit 0 reads 1 with no enables
			s_r <= '0;
			s_r.thr_sel <= UFC_RST_THR;
			s_r.ie <= UFC_RST_IE;
		end else begin
			// Normal run: take the next state
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	// Every output is a field of the state register
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign tx_head = s_r.tx_head;
	assign tx_avail = s_r.tx_avail;
	assign irq = s_r.irq;

endmodule : ufc_queue_ctrl

`default_nettype wire

//--- ufc_pkg.sv
package ufc_pkg;

	//////////////////////////////////////////////////////////////////////
	// Register indices and byte addresses (one aligned word each)
	localparam logic [7:0] UFC_IDX_DATA = 8'h00; // Receive pop / send push
	localparam logic [7:0] UFC_IDX_IRQ_EN = 8'h01; // Source enables
	localparam logic [7:0] UFC_IDX_QCTL = 8'h02; // Queue control / identity
	localparam logic [7:0] UFC_IDX_LSTAT = 8'h03; // Line error status
	localparam logic [7:0] UFC_IDX_EVT_STAT = 8'h04; // Sticky events
	localparam logic [7:0] UFC_IDX_EVT_CLR = 8'h05; // Event clear
	localparam logic [7:0] UFC_IDX_EVT_EN = 8'h06; // Event enables
	localparam logic [9:0] UFC_ADDR_DATA = {UFC_IDX_DATA, 2'b00};
	localparam logic [9:0] UFC_ADDR_IRQ_EN = {UFC_IDX_IRQ_EN, 2'b00};
	localparam logic [9:0] UFC_ADDR_QCTL = {UFC_IDX_QCTL, 2'b00};
	localparam logic [9:0] UFC_ADDR_LSTAT = {UFC_IDX_LSTAT, 2'b00};
	localparam logic [9:0] UFC_ADDR_EVT_STAT = {UFC_IDX_EVT_STAT, 2'b00};
	localparam logic [9:0] UFC_ADDR_EVT_CLR = {UFC_IDX_EVT_CLR, 2'b00};
	localparam logic [9:0] UFC_ADDR_EVT_EN = {UFC_IDX_EVT_EN, 2'b00};

	//////////////////////////////////////////////////////////////////////
	// Queue control field positions
	localparam int UFC_QC_EN = 0; // queues_enable
	localparam int UFC_QC_RX_FLUSH = 1; // rx_queue_flush
	localparam int UFC_QC_TX_FLUSH = 2; // tx_queue_flush
	localparam int UFC_QC_XFER_MODE = 3; // No effect
	localparam int UFC_QC_THR_LO = 6; // rx_threshold_sel low bit

	// Source enable positions
	localparam int UFC_IE_RXAV = 0; // rx_avail_irq_enable
	localparam int UFC_IE_THRE = 1;
	localparam int UFC_IE_LINE = 2;
	localparam int UFC_IE_MODEM = 3;

	// Event bit positions
	localparam int UFC_EV_LINE = 0;
	localparam int UFC_EV_RXAV = 1;
	localparam int UFC_EV_THRE = 2;
	localparam int UFC_EV_MODEM = 3;
	localparam int UFC_EV_TMO = 4;
	localparam int UFC_EV_W = 5;

	//////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [1:0] UFC_RST_THR = 2'h0;
	localparam logic [3:0] UFC_RST_IE = 4'h0;
	localparam logic [7:0] UFC_RST_IDENT = 8'h01;

	// Pending source codes (identity bits 3:1)
	localparam logic [2:0] UFC_SRC_LINE = 3'h3;
	localparam logic [2:0] UFC_SRC_RXAV = 3'h2;
	localparam logic [2:0] UFC_SRC_TMO = 3'h6;
	localparam logic [2:0] UFC_SRC_THRE = 3'h1;
	localparam logic [2:0] UFC_SRC_MODEM = 3'h0;
	localparam logic [2:0] UFC_SRC_NONE = 3'h0;

	//////////////////////////////////////////////////////////////////////
	// Queue sizes, thresholds and timing
	localparam logic [4:0] UFC_DEPTH = 5'h10;
	localparam logic [4:0] UFC_HOLD_DEPTH = 5'h01;
	localparam logic [4:0] UFC_TRIG_0 = 5'h01;
	localparam logic [4:0] UFC_TRIG_1 = 5'h04;
	localparam logic [4:0] UFC_TRIG_2 = 5'h08;
	localparam logic [4:0] UFC_TRIG_3 = 5'h0e;
	localparam logic [2:0] UFC_TMO_CHARS = 3'h4; // Character times

	// Line error flags from the receiver
	typedef struct packed {
		logic brk; // Break seen
		logic frm; // Framing error
		logic par; // Parity error
		logic ovr; // Overrun in the shift register path
	} ufc_line_err_t;

endpackage : ufc_pkg

//--- ufc_queue_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
// Port checks of the queue control and identity block
module ufc_queue_ctrl_assertions
	import ufc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Send side
	input wire logic tx_avail
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic done; // Access completes
	logic rd08; // Identity read completes
	logic wr08; // Control write completes
	logic en_r; // Shadow of the queue enable
	assign done = psel && penable && pready;
	assign rd08 = done && !pwrite && paddr[11:2] == UFC_ADDR_QCTL[9:2];
	assign wr08 = done && pwrite && paddr[11:2] == UFC_ADDR_QCTL[9:2];
	// Track the enable as last written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			en_r <= 1'b0;
		else if (wr08)
			en_r <= pwdata[UFC_QC_EN];
	end
	//////////////////////////////////////////////////////////////////////
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready held too long");
	property p_err; done && paddr[11:2] > 10'h6 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped not flagged");
	property p_en; rd08 |-> prdata[7:6] == {2{en_r}}; endproperty
	a_en: assert property (p_en) else $error("mode bits wrong");
	property p_rsv; rd08 |-> prdata[5:4] == 2'b00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_b3; rd08 && !en_r |-> !prdata[3]; endproperty
	a_b3: assert property (p_b3) else $error("timeout bit set");
	property p_none; rd08 && prdata[0] |-> prdata[3:1] == 3'h0; endproperty
	a_none: assert property (p_none) else $error("code w/o pend");
	property p_code;
		rd08 |-> prdata[3:1] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
	endproperty
	a_code: assert property (p_code) else $error("bad code");
	property p_txf; wr08 && pwdata[0] && pwdata[2] |-> ##[1:2] !tx_avail;
	endproperty
	a_txf: assert property (p_txf) else $error("send not flushed");
	// Main scenarios reached
	c_pend: cover property (rd08 && !prdata[0]);
	c_txf: cover property (wr08 && pwdata[2]);
	c_err: cover property (done && pslverr);
endmodule : ufc_queue_ctrl_assertions
`default_nettype wire

//--- ufc_far_end.sv
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
// Serial side: character clock and send shifter
module ufc_far_end (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench controls
	input wire logic tick_en,
	input wire logic stall,
	// Send queue head
	input wire logic tx_avail,
	input wire logic [7:0] tx_head,
	output logic tx_take,
	output logic char_tick,
	output logic [7:0] last_byte,
	output logic [7:0] taken
);
	logic [1:0] div_r; // Cycles per character
	// One tick every four cycles, only while allowed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 2'h0;
			char_tick <= 1'b0;
		end else begin
			div_r <= div_r + 2'h1;
			char_tick <= tick_en && div_r == 2'h3;
		end
	end
	// Take only a shown head; skip a cycle so the head can move on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_take <= 1'b0;
			last_byte <= 8'h00;
			taken <= 8'h00;
		end else begin
			tx_take <= tx_avail && !stall && !tx_take;
			if (tx_take) begin
				last_byte <= tx_head;
				taken <= taken + 8'h01;
			end
		end
	end
endmodule : ufc_far_end
`default_nettype wire

//--- ufc_queue_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_queue_ctrl_tb;
	import ufc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, err;
	logic rx_wr = 1'b0;
	logic [7:0] rx_byte = 8'h00;
	ufc_line_err_t rx_err = '0;
	logic modem_pend = 1'b0;
	logic tick_en = 1'b0;
	logic stall = 1'b0;
	logic pce = 1'b1;
	logic char_tick, tx_take, tx_avail, irq;
	logic [7:0] tx_head, last_byte, taken, b;
	logic [31:0] rd;
	logic [7:0] q[$];
	int mismatches = 0;
	int check_count = 0;
	ufc_queue_ctrl dut_u (.pclk, .presetn, .pce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_wr,
		.rx_byte, .rx_err, .char_tick, .tx_take, .tx_avail, .tx_head,
		.modem_pend, .irq);
	ufc_far_end far_u (.pclk, .presetn, .tick_en, .stall, .tx_avail,
		.tx_head, .tx_take, .char_tick, .last_byte, .taken);
	initial begin
		forever #5 pclk = ~pclk;
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
		check_count++;
		if (got !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, got);
			mismatches++;
		end
	endtask : chk
	// One APB transfer, held until ready is sampled
	task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	function logic [31:0] idv(input logic en, logic [2:0] c, logic n);
		return {24'h0, en, en, 2'b00, c, n};
	endfunction : idv
	function int thr(input int s);
		return s == 0 ? 1 : s == 1 ? 4 : s == 2 ? 8 : 14;
	endfunction : thr
	task idr(input logic [31:0] e);
		apb(1'b0, UFC_ADDR_QCTL, 32'h0);
		chk("identity", rd, e);
	endtask : idr
	task push(input logic [7:0] v);
		rx_byte <= v;
		rx_wr <= 1'b1;
		q.push_back(v);
		@(posedge pclk);
		rx_wr <= 1'b0;
		@(posedge pclk);
	endtask : push
	task pop;
		apb(1'b0, UFC_ADDR_DATA, 32'h0);
		chk("rx data", rd, {24'h0, q.pop_front()});
	endtask : pop
	initial begin
		b = 8'($urandom(37));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		idr(32'h1);
		apb(1'b0, 10'h01c, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		$display("reset test done");
		apb(1'b1, UFC_ADDR_IRQ_EN, 32'h1);
		apb(1'b1, UFC_ADDR_EVT_EN, 32'h2);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, UFC_ADDR_QCTL, {24'h0, 2'(s), 6'h03});
			apb(1'b0, UFC_ADDR_LSTAT, 32'h0);
			chk("rx flushed", rd, 32'h0);
			q.delete();
			repeat (thr(s) - 1) push(8'($urandom));
			idr(idv(1'b1, UFC_SRC_NONE, 1'b1));
			push(8'($urandom));
			idr(idv(1'b1, UFC_SRC_RXAV, 1'b0));
			chk("irq", {31'h0, irq}, 32'h1);
			pop();
			apb(1'b1, UFC_ADDR_EVT_CLR, 32'h1f);
			repeat (2) @(posedge pclk);
			chk("irq", {31'h0, irq}, 32'h0);
		end
		$display("threshold test done");
		apb(1'b1, UFC_ADDR_QCTL, 32'h43);
		q.delete();
		push(8'($urandom));
		tick_en <= 1'b1;
		repeat (24) @(posedge pclk);
		tick_en <= 1'b0;
		idr(idv(1'b1, UFC_SRC_TMO, 1'b0));
		apb(1'b1, UFC_ADDR_IRQ_EN, 32'h0);
		idr(idv(1'b1, UFC_SRC_NONE, 1'b1));
		pop();
		apb(1'b1, UFC_ADDR_IRQ_EN, 32'hf);
		apb(1'b1, UFC_ADDR_QCTL, 32'h03);
		rx_err <= ufc_line_err_t'(4'h1);
		@(posedge pclk);
		rx_err <= ufc_line_err_t'(4'h0);
		push(8'($urandom));
		modem_pend <= 1'b1;
		idr(idv(1'b1, UFC_SRC_LINE, 1'b0));
		apb(1'b0, UFC_ADDR_LSTAT, 32'h0);
		chk("line status", rd, 32'h11);
		idr(idv(1'b1, UFC_SRC_RXAV, 1'b0));
		pop();
		idr(idv(1'b1, UFC_SRC_THRE, 1'b0));
		idr(idv(1'b1, UFC_SRC_MODEM, 1'b0));
		modem_pend <= 1'b0;
		idr(idv(1'b1, UFC_SRC_NONE, 1'b1));
		$display("priority test done");
		stall <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, UFC_ADDR_DATA, {24'h0, 8'($urandom)});
			if (i == 0)
				b = pwdata[7:0];
		end
		chk("tx head", {24'h0, tx_head}, {24'h0, b});
		apb(1'b1, UFC_ADDR_QCTL, 32'h05);
		repeat (2) @(posedge pclk);
		chk("tx avail", {31'h0, tx_avail}, 32'h0);
		stall <= 1'b0;
		b = 8'($urandom);
		apb(1'b1, UFC_ADDR_DATA, {24'h0, b});
		for (int n = 0; n < 20 && taken !== 8'h01; n++)
			@(posedge pclk);
		chk("taken", {24'h0, taken}, 32'h1);
		chk("sent", {24'h0, last_byte}, {24'h0, b});
		if (taken !== 8'h01)
			end_of_test();
		push(8'($urandom));
		apb(1'b1, UFC_ADDR_QCTL, 32'h09);
		pop();
		$display("send test done");
		push(8'($urandom));
		apb(1'b1, UFC_ADDR_IRQ_EN, 32'h1);
		apb(1'b1, UFC_ADDR_QCTL, 32'h0);
		idr(idv(1'b0, UFC_SRC_NONE, 1'b1));
		q.delete();
		push(8'($urandom));
		push(8'($urandom));
		void'(q.pop_back());
		idr(idv(1'b0, UFC_SRC_RXAV, 1'b0));
		pop();
		pce <= 1'b0;
		push(8'($urandom));
		void'(q.pop_back());
		pce <= 1'b1;
		apb(1'b0, UFC_ADDR_LSTAT, 32'h0);
		chk("line status", rd, 32'h1);
		$display("single byte test done");
		end_of_test();
	end
endmodule : ufc_queue_ctrl_tb
bind ufc_queue_ctrl ufc_queue_ctrl_assertions chk_u (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tx_avail(tx_avail));
`default_nettype wire
